// *** rtl/hub_power_port_config.sv ***
// power and port configuration byte bank of a seven-port hub
// written at start-up by a config loader on a byte port; one clock
//
// Behaviour
// - In bus-powered mode each set bit 7..1 of the port-off mask turns off port 7..1.
// - Bit 0 of the port-off mask is reserved; writers put zero there and it is held zero.
// - The self-powered power limit byte counts 2 mA units and is reported in self mode.
// - The bus-powered power limit byte counts 2 mA units and is reported in bus mode.
// - The self-mode controller current counts 2 mA units and resets to 50.
// - The bus-mode controller current counts 2 mA units and resets to 50.
// - Every power and current byte times two is its value in milliamps.
// - The power-on delay byte counts 2 ms units to power good and is reported as such.
// - With dynamic switching on, the supply sense pin picks the power mode, not the bit.
`timescale 1ns/1ps
module hub_power_port_config
  import hub_power_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // config byte port from the loader
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [ADDR_W-1:0] cfg_addr_i,
  input wire logic [DATA_W-1:0] cfg_wdata_i,
  output logic [DATA_W-1:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // power mode inputs
  input wire logic dynamic_switch_en_i,
  input wire logic self_power_cfg_i,
  input wire logic local_supply_sense_i,
  input wire logic [PORT_N:1] self_port_off_i,
  // applied values
  output logic self_powered_o,
  output logic [PORT_N:1] port_off_o,
  output logic [DATA_W-1:0] power_limit_code_o,
  output logic [DATA_W:0] power_limit_ma_o,
  output logic [DATA_W-1:0] controller_current_code_o,
  output logic [DATA_W:0] controller_current_ma_o,
  output logic [DATA_W-1:0] power_on_delay_code_o,
  output logic [DATA_W:0] power_on_delay_ms_o,
  output logic self_limit_exceeded_o
);
  typedef struct packed {
    logic [DATA_W-1:0] bus_powered_port_off_mask;
    logic [DATA_W-1:0] self_powered_power_limit;
    logic [DATA_W-1:0] bus_powered_power_limit;
    logic [DATA_W-1:0] controller_current_self;
    logic [DATA_W-1:0] controller_current_bus;
    logic [DATA_W-1:0] port_power_on_delay;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic self_powered;
    logic [PORT_N:1] port_off;
    logic [DATA_W-1:0] power_limit_code;
    logic [DATA_W:0] power_limit_ma;
    logic [DATA_W-1:0] ctrl_code;
    logic [DATA_W:0] ctrl_ma;
    logic [DATA_W-1:0] delay_code;
    logic [DATA_W:0] delay_ms;
    logic over;
  } bank_state_t;

  bank_state_t st_ff;
  bank_state_t nxt_st;
  logic supply_sense;
  logic mode_self;
  logic [DATA_W-1:0] limit_sel;
  logic [DATA_W-1:0] ctrl_sel;
  logic [DATA_W:0] limit_ma;
  logic [DATA_W:0] ctrl_ma;
  logic limit_over;
  logic ctrl_over;

  function automatic logic [DATA_W-1:0] read_mux(input bank_state_t s,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      OFF_PORT_DISABLE_BUS: r = s.bus_powered_port_off_mask;
      OFF_MAX_POWER_SELF: r = s.self_powered_power_limit;
      OFF_MAX_POWER_BUS: r = s.bus_powered_power_limit;
      OFF_CTRL_CURRENT_SELF: r = s.controller_current_self;
      OFF_CTRL_CURRENT_BUS: r = s.controller_current_bus;
      OFF_POWER_ON_DELAY: r = s.port_power_on_delay;
      default: r = '0;
    endcase
    return r;
  endfunction : read_mux

  level_sync3 u_sense_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .pin_i(local_supply_sense_i),
    .level_o(supply_sense)
  );

  // sense pin overrides the strap bit under dynamic switching
  assign mode_self = dynamic_switch_en_i ? supply_sense : self_power_cfg_i;
  assign limit_sel = mode_self ? st_ff.self_powered_power_limit
                               : st_ff.bus_powered_power_limit;
  assign ctrl_sel = mode_self ? st_ff.controller_current_self
                              : st_ff.controller_current_bus;

  milliamp_scale u_limit_scale (
    .code_i(limit_sel),
    .milliamp_o(limit_ma),
    .over_limit_o(limit_over)
  );

  milliamp_scale u_ctrl_scale (
    .code_i(ctrl_sel),
    .milliamp_o(ctrl_ma),
    .over_limit_o(ctrl_over)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (cfg_wr_i) begin
      case (cfg_addr_i)
        OFF_PORT_DISABLE_BUS: begin
          nxt_st.bus_powered_port_off_mask = cfg_wdata_i;
          nxt_st.bus_powered_port_off_mask[RESERVED_BIT] = 1'b0;
        end
        OFF_MAX_POWER_SELF: nxt_st.self_powered_power_limit = cfg_wdata_i;
        OFF_MAX_POWER_BUS: nxt_st.bus_powered_power_limit = cfg_wdata_i;
        OFF_CTRL_CURRENT_SELF: nxt_st.controller_current_self = cfg_wdata_i;
        OFF_CTRL_CURRENT_BUS: nxt_st.controller_current_bus = cfg_wdata_i;
        OFF_POWER_ON_DELAY: nxt_st.port_power_on_delay = cfg_wdata_i;
        default: nxt_st.rvalid = 1'b0;
      endcase
    end
    if (cfg_rd_i) begin
      nxt_st.rdata = read_mux(st_ff, cfg_addr_i);
      nxt_st.rvalid = 1'b1;
    end
    nxt_st.self_powered = mode_self;
    // set bit turns the port off only in bus-powered mode
    nxt_st.port_off = mode_self ? self_port_off_i
                                : st_ff.bus_powered_port_off_mask[PORT_N:1];
    nxt_st.power_limit_code = limit_sel;
    nxt_st.power_limit_ma = limit_ma;
    nxt_st.ctrl_code = ctrl_sel;
    nxt_st.ctrl_ma = ctrl_ma;
    nxt_st.delay_code = st_ff.port_power_on_delay;
    nxt_st.delay_ms = {st_ff.port_power_on_delay, 1'b0};
    // advisory only: self-mode codes above 50 break the bus limit
    nxt_st.over = mode_self & (limit_over | ctrl_over);
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.bus_powered_port_off_mask <= RST_PORT_DISABLE;
      st_ff.self_powered_power_limit <= RST_MAX_POWER;
      st_ff.bus_powered_power_limit <= RST_MAX_POWER;
      st_ff.controller_current_self <= RST_CTRL_CURRENT;
      st_ff.controller_current_bus <= RST_CTRL_CURRENT;
      st_ff.port_power_on_delay <= RST_POWER_ON_DELAY;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg_rdata_o = st_ff.rdata;
  assign cfg_rvalid_o = st_ff.rvalid;
  assign self_powered_o = st_ff.self_powered;
  assign port_off_o = st_ff.port_off;
  assign power_limit_code_o = st_ff.power_limit_code;
  assign power_limit_ma_o = st_ff.power_limit_ma;
  assign controller_current_code_o = st_ff.ctrl_code;
  assign controller_current_ma_o = st_ff.ctrl_ma;
  assign power_on_delay_code_o = st_ff.delay_code;
  assign power_on_delay_ms_o = st_ff.delay_ms;
  assign self_limit_exceeded_o = st_ff.over;
endmodule : hub_power_port_config

// *** rtl/hub_power_cfg_pkg.sv ***
// constants for the power and port configuration bank
// shared by the bank top and its helper modules
package hub_power_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PORT_N = 7;
  localparam logic [7:0] OFF_PORT_DISABLE_BUS = 8'h0a;
  localparam logic [7:0] OFF_MAX_POWER_SELF = 8'h0b;
  localparam logic [7:0] OFF_MAX_POWER_BUS = 8'h0c;
  localparam logic [7:0] OFF_CTRL_CURRENT_SELF = 8'h0d;
  localparam logic [7:0] OFF_CTRL_CURRENT_BUS = 8'h0e;
  localparam logic [7:0] OFF_POWER_ON_DELAY = 8'h0f;
  localparam int RESERVED_BIT = 0;
  localparam logic [7:0] RST_PORT_DISABLE = 8'h00;
  localparam logic [7:0] RST_MAX_POWER = 8'h00;
  localparam logic [7:0] RST_CTRL_CURRENT = 8'h32;
  localparam logic [7:0] RST_POWER_ON_DELAY = 8'h00;
  localparam int MA_PER_UNIT = 2;
  localparam int MS_PER_UNIT = 2;
  localparam int SELF_LIMIT_CODE = 50;
  localparam int SYNC_STAGES = 3;
endpackage : hub_power_cfg_pkg

// *** rtl/level_sync3.sv ***
// three-stage synchroniser for a pin level
// assumes one clock; output changes once stages two and three agree
`timescale 1ns/1ps
module level_sync3
  import hub_power_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // pin and clean level
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic level;
  } sync_state_t;
  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage = {st_ff.stage[SYNC_STAGES-2:0], pin_i};
    if (st_ff.stage[1] == st_ff.stage[2]) begin
      nxt_st.level = st_ff.stage[2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.level;
endmodule : level_sync3

// *** rtl/milliamp_scale.sv ***
// turns a 2 mA unit code into milliamps and flags codes above the limit
// purely combinational, same clock as the caller
`timescale 1ns/1ps
module milliamp_scale
  import hub_power_cfg_pkg::*;
(
  // code in
  input wire logic [DATA_W-1:0] code_i,
  // scaled value out
  output logic [DATA_W:0] milliamp_o,
  output logic over_limit_o
);
  // stored value times two gives milliamps
  assign milliamp_o = {code_i, 1'b0};
  assign over_limit_o = (code_i > DATA_W'(SELF_LIMIT_CODE));
endmodule : milliamp_scale

// *** sim/hub_power_port_config_monitor.sv ***
// assertion checker on the bank ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module hub_power_port_config_monitor
  import hub_power_cfg_pkg::*;
(
  // bank ports
  input wire logic clk_sys_i, srst_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o,
  input wire logic dynamic_switch_en_i, self_power_cfg_i, local_supply_sense_i,
  input wire logic self_powered_o, self_limit_exceeded_o,
  input wire logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, power_limit_code_o,
  input wire logic [7:0] controller_current_code_o, power_on_delay_code_o,
  input wire logic [8:0] power_limit_ma_o, controller_current_ma_o, power_on_delay_ms_o,
  input wire logic [7:1] self_port_off_i, port_off_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  property p_bus_off;
    cfg_wr_i && cfg_addr_i == OFF_PORT_DISABLE_BUS ##1 !self_powered_o [*2]
      |-> port_off_o == $past(cfg_wdata_i[7:1], 2);
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("port mask not applied");
  property p_bus_lim;
    cfg_wr_i && cfg_addr_i == OFF_MAX_POWER_BUS ##1 !self_powered_o [*2]
      |-> power_limit_code_o == $past(cfg_wdata_i, 2);
  endproperty
  a_bus_lim: assert property (p_bus_lim) else $error("bus limit not applied");
  property p_self_lim;
    cfg_wr_i && cfg_addr_i == OFF_MAX_POWER_SELF ##1 self_powered_o [*2]
      |-> power_limit_code_o == $past(cfg_wdata_i, 2);
  endproperty
  a_self_lim: assert property (p_self_lim) else $error("self limit not applied");
  property p_lim_ma;
    power_limit_ma_o == {power_limit_code_o, 1'b0};
  endproperty
  a_lim_ma: assert property (p_lim_ma) else $error("limit scale wrong");
  property p_cc_ma;
    controller_current_ma_o == {controller_current_code_o, 1'b0};
  endproperty
  a_cc_ma: assert property (p_cc_ma) else $error("current scale wrong");
  property p_dly_ms;
    power_on_delay_ms_o == {power_on_delay_code_o, 1'b0};
  endproperty
  a_dly_ms: assert property (p_dly_ms) else $error("delay scale wrong");
  property p_rst_cc;
    $fell(srst_i) |=> controller_current_code_o == RST_CTRL_CURRENT;
  endproperty
  a_rst_cc: assert property (p_rst_cc) else $error("current default wrong");
  property p_rd0;
    cfg_rd_i && cfg_addr_i == OFF_PORT_DISABLE_BUS |=> !cfg_rdata_o[RESERVED_BIT];
  endproperty
  a_rd0: assert property (p_rd0) else $error("reserved bit set");
  property p_dyn;
    (dynamic_switch_en_i && $stable(local_supply_sense_i)) [*8]
      |-> self_powered_o == local_supply_sense_i;
  endproperty
  a_dyn: assert property (p_dyn) else $error("sense pin ignored");
  c_off: cover property (cfg_wr_i && cfg_addr_i == OFF_PORT_DISABLE_BUS);
  c_over: cover property (self_limit_exceeded_o);
  c_dyn: cover property (dynamic_switch_en_i && self_powered_o);
endmodule : hub_power_port_config_monitor
bind hub_power_port_config hub_power_port_config_monitor u_mon (.*);

// *** sim/cfg_loader.sv ***
// loader model: one byte write or read per call
// assumes the bank samples strobes on the rising edge
`timescale 1ns/1ps
module cfg_loader (
  // clock
  input wire logic clk_sys_i,
  // byte port
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] data_o = 8'h00
);
  task automatic xfer(input logic w, r, input logic [7:0] a, d);
    @(posedge clk_sys_i);
    wr_o <= w;
    rd_o <= r;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    data_o <= ~d;
  endtask : xfer
endmodule : cfg_loader

// *** sim/hub_power_port_config_bench.sv ***
// bench: random loads, power mode sweep, read-back against a model
// assumes the loader model drives the byte port
`timescale 1ns/1ps
module hub_power_port_config_bench
  import hub_power_cfg_pkg::*;
;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, dyn = 1'b0, cfg = 1'b0, sense = 1'b0, s;
  logic wr, rd, rv, self_o, over;
  logic [7:1] sp_off = 7'h00, off;
  logic [7:0] a, wd, rdat, lim, cc, dly, v, seed = 8'h57;
  logic [8:0] lim_ma, cc_ma, dly_ms;
  int miscompares = 0, tests_run = 0;
  int mdl [int];
  always #2.5 clk_sys_i = ~clk_sys_i;
  cfg_loader ld (.clk_sys_i(clk_sys_i), .wr_o(wr), .rd_o(rd), .addr_o(a), .data_o(wd));
  hub_power_port_config dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .cfg_wr_i(wr),
    .cfg_rd_i(rd), .cfg_addr_i(a), .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv),
    .dynamic_switch_en_i(dyn), .self_power_cfg_i(cfg), .local_supply_sense_i(sense),
    .self_port_off_i(sp_off), .self_powered_o(self_o), .port_off_o(off),
    .power_limit_code_o(lim), .power_limit_ma_o(lim_ma), .controller_current_code_o(cc),
    .controller_current_ma_o(cc_ma), .power_on_delay_code_o(dly),
    .power_on_delay_ms_o(dly_ms), .self_limit_exceeded_o(over));
  function automatic logic [7:0] nx(input logic [7:0] q);
    return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
  endfunction : nx
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #5000;
    miscompares++;
    wrap_up();
  end
  initial begin
    for (int i = 10; i < 16; i++) mdl[i] = (i == 13 || i == 14) ? 8'h32 : 8'h00;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      // round 0 keeps reset values; address 0x10 is unmapped
      if (r > 0) for (int i = 10; i < 17; i++) begin
        seed = nx(seed);
        v = (i == 11 || i == 13) ? (r == 2 ? 8'h33 : seed % 8'h33) : seed;
        // limit bytes are taken to already include any embedded peripheral draw
        ld.xfer(1'b1, 1'b0, 8'(i), v);
        if (i < 16) mdl[i] = (i == 10) ? (v & 8'hfe) : v;
      end
      @(posedge clk_sys_i);
      dyn <= r[1];
      cfg <= r[0];
      sense <= ~r[0];
      sp_off <= seed[7:1];
      repeat (8) @(posedge clk_sys_i);
      #1;
      s = dyn ? sense : cfg;
      chk(self_o, s);
      chk(off, s ? sp_off : mdl[10][7:1]);
      chk(lim, mdl[s ? 11 : 12]);
      chk(lim_ma, 2 * mdl[s ? 11 : 12]);
      chk(cc, mdl[s ? 13 : 14]);
      chk(cc_ma, 2 * mdl[s ? 13 : 14]);
      chk(dly, mdl[15]);
      chk(dly_ms, 2 * mdl[15]);
      chk(over, s && (mdl[11] > 50 || mdl[13] > 50));
      for (int i = 9; i < 17; i++) begin
        ld.xfer(1'b0, 1'b1, 8'(i), 8'h00);
        #1;
        chk(rv, 1'b1);
        chk(rdat, mdl.exists(i) ? mdl[i] : 0);
      end
    end
    wrap_up();
  end
endmodule : hub_power_port_config_bench
